// [rtl/fcaf_host.sv]
// Host controller that drives a byte-wide parallel flash through its pins
`timescale 1ns/1ps
`default_nettype none

// Function
// - High-voltage id: pin high, A6 low
// - Sector address on top bits for status
// - Write only with select, strobe low, gate high
// - Host resets after time-limit or id mode
// - Unlock, unlock, id command enters id mode
// - Read: select, gate low, strobe high
module fcaf_host
	import fcaf_pkg::*;
(
	// Clock and reset
	input wire logic sys_clk,
	input wire logic arst_n,
	// User command port
	input wire logic cmd_valid,
	input wire fcaf_pkg::fcaf_cmd_t cmd,
	output logic cmd_ready,
	output logic rsp_valid,
	output fcaf_pkg::fcaf_rsp_t rsp,
	output logic id_mode,
	output logic time_limit_seen,
	// Flash pins
	output logic [fcaf_pkg::ADDR_W-1:0] flash_addr,
	output logic flash_ce_n,
	output logic flash_oe_n,
	output logic flash_we_n,
	output logic id_detect_pin,
	input wire logic [fcaf_pkg::DATA_W-1:0] byte_lines_i,
	output logic [fcaf_pkg::DATA_W-1:0] byte_lines_o,
	output logic byte_lines_oe
);
	import fcaf_pkg::*;

	typedef enum logic [2:0] {
		ST_IDLE, ST_WSET, ST_WLOW, ST_WHIGH, ST_HV, ST_RLOW, ST_DONE
	} fcaf_state_t;

	fcaf_state_t state_q;
	fcaf_cmd_t cmd_q;
	logic [1:0] nwr_q;
	logic [1:0] idx_q;
	logic rd_q;
	logic [3:0] cnt_q;
	logic [DATA_W-1:0] s1_q, s2_q, s3_q;
	fcaf_word_t word;

	////////////////////////////////////////////////////////////////////////////////
	// Write sequence table

	function automatic fcaf_word_t step_word(input fcaf_cmd_t c, input logic [1:0] idx);
		fcaf_word_t w;
		w = '{addr: RESET_ADDR, data: RESET_DATA};
		case (c.op)
			FCAF_OP_WRITE: w = '{addr: c.addr, data: c.data};
			FCAF_OP_AUTOSEL: begin
				case (idx)
					2'h0: w = '{addr: UNLOCK1_ADDR, data: UNLOCK1_DATA};
					2'h1: w = '{addr: UNLOCK2_ADDR, data: UNLOCK2_DATA};
					default: w = '{addr: UNLOCK1_ADDR, data: AUTOSEL_DATA};
				endcase
			end
			default: w = '{addr: RESET_ADDR, data: RESET_DATA};
		endcase
		return w;
	endfunction

	assign word = step_word(cmd_q, idx_q);

	////////////////////////////////////////////////////////////////////////////////
	// Byte line synchroniser; only stages two and three are compared

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			s1_q <= '0;
			s2_q <= '0;
			s3_q <= '0;
		end else begin
			s1_q <= byte_lines_i;
			s2_q <= s1_q;
			s3_q <= s2_q;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Sequencer and pin drive

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			// Strobes idle high so nothing is written while the part powers up
			state_q <= ST_IDLE;
			cmd_q <= '0;
			nwr_q <= '0;
			idx_q <= '0;
			rd_q <= 1'b0;
			cnt_q <= '0;
			cmd_ready <= 1'b0;
			rsp_valid <= 1'b0;
			rsp <= '0;
			flash_addr <= '0;
			flash_ce_n <= 1'b1;
			flash_oe_n <= 1'b1;
			flash_we_n <= 1'b1;
			id_detect_pin <= 1'b0;
			byte_lines_o <= '0;
			byte_lines_oe <= 1'b0;
		end else begin
			rsp_valid <= 1'b0;
			case (state_q)
				ST_IDLE: begin
					cmd_ready <= 1'b1;
					if (cmd_valid && cmd_ready) begin
						cmd_ready <= 1'b0;
						cmd_q <= cmd;
						idx_q <= '0;
						rd_q <= 1'b0;
						nwr_q <= 2'h0;
						case (cmd.op)
							FCAF_OP_WRITE, FCAF_OP_RESET: nwr_q <= 2'h1;
							FCAF_OP_AUTOSEL: nwr_q <= AUTOSEL_WRITES;
							FCAF_OP_READ: begin
								// Array reads need a reset first after id mode or a time-out
								nwr_q <= (id_mode || time_limit_seen) ? 2'h1 : 2'h0;
								rd_q <= 1'b1;
							end
							default: rd_q <= 1'b1;
						endcase
						if (cmd.op == FCAF_OP_HV_READ) begin
							state_q <= ST_HV;
							cnt_q <= HV_WAIT;
							id_detect_pin <= 1'b1;
							flash_addr <= cmd.addr;
							flash_addr[ID_A6_BIT] <= 1'b0;
						end else if (cmd.op == FCAF_OP_READ && !(id_mode || time_limit_seen)) begin
							state_q <= ST_RLOW;
							cnt_q <= RD_WAIT;
							flash_addr <= cmd.addr;
							flash_ce_n <= 1'b0;
							flash_oe_n <= 1'b0;
						end else if (cmd.op == FCAF_OP_ID_READ) begin
							state_q <= ST_RLOW;
							cnt_q <= RD_WAIT;
							flash_addr <= cmd.addr;
							flash_ce_n <= 1'b0;
							flash_oe_n <= 1'b0;
						end else begin
							state_q <= ST_WSET;
						end
					end
				end
				ST_WSET: begin
					// Gate stays high across the whole write cycle
					flash_oe_n <= 1'b1;
					flash_ce_n <= 1'b0;
					flash_addr <= word.addr;
					byte_lines_o <= word.data;
					byte_lines_oe <= 1'b1;
					cnt_q <= WP_WAIT;
					state_q <= ST_WLOW;
				end
				ST_WLOW: begin
					flash_we_n <= 1'b0;
					if (cnt_q <= 4'h1) begin
						state_q <= ST_WHIGH;
					end else begin
						cnt_q <= cnt_q - 4'h1;
					end
				end
				ST_WHIGH: begin
					// Data stays driven one cycle past the strobe for hold time
					flash_we_n <= 1'b1;
					flash_ce_n <= 1'b1;
					if (flash_we_n) begin
						byte_lines_oe <= 1'b0;
						if (idx_q + 2'h1 < nwr_q) begin
							idx_q <= idx_q + 2'h1;
							state_q <= ST_WSET;
						end else if (rd_q) begin
							state_q <= ST_RLOW;
							cnt_q <= RD_WAIT;
							flash_addr <= cmd_q.addr;
							flash_ce_n <= 1'b0;
							flash_oe_n <= 1'b0;
						end else begin
							state_q <= ST_DONE;
						end
					end
				end
				ST_HV: begin
					if (cnt_q <= 4'h1) begin
						state_q <= ST_RLOW;
						cnt_q <= RD_WAIT;
						flash_ce_n <= 1'b0;
						flash_oe_n <= 1'b0;
					end else begin
						cnt_q <= cnt_q - 4'h1;
					end
				end
				ST_RLOW: begin
					if (cnt_q != 4'h0) begin
						cnt_q <= cnt_q - 4'h1;
					end else if (s2_q == s3_q) begin
						rsp.data <= s3_q;
						rsp.time_limit_flag <= s3_q[TLF_BIT];
						flash_ce_n <= 1'b1;
						flash_oe_n <= 1'b1;
						id_detect_pin <= 1'b0;
						state_q <= ST_DONE;
					end
				end
				ST_DONE: begin
					rsp_valid <= 1'b1;
					state_q <= ST_IDLE;
				end
				default: state_q <= ST_IDLE;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Tracked device mode

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			id_mode <= 1'b0;
			time_limit_seen <= 1'b0;
		end else if (state_q == ST_DONE) begin
			if (cmd_q.op == FCAF_OP_AUTOSEL) begin
				id_mode <= 1'b1;
			end else if (cmd_q.op == FCAF_OP_RESET || (cmd_q.op == FCAF_OP_READ && !rd_q)) begin
				id_mode <= 1'b0;
				time_limit_seen <= 1'b0;
			end
		end else if (state_q == ST_WHIGH && flash_we_n && word.data == RESET_DATA
			&& cmd_q.op != FCAF_OP_WRITE) begin
			// A reset prefixed to an array read clears the tracked mode
			id_mode <= 1'b0;
			time_limit_seen <= 1'b0;
		end else if (state_q == ST_RLOW && cnt_q == 4'h0 && s2_q == s3_q
			&& cmd_q.op == FCAF_OP_READ && s3_q[TLF_BIT]) begin
			time_limit_seen <= 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Checks

	a_write_strobe_qual: assert property (@(posedge sys_clk) disable iff (!arst_n)
		!flash_we_n |-> !flash_ce_n && flash_oe_n && byte_lines_oe)
		else $error("write strobe low without select low and gate high");
	a_read_levels: assert property (@(posedge sys_clk) disable iff (!arst_n)
		!flash_oe_n |-> !flash_ce_n && flash_we_n && !byte_lines_oe)
		else $error("read with bad control levels or host driving bytes");
	a_write_pulse_len: assert property (@(posedge sys_clk) disable iff (!arst_n)
		$fell(flash_we_n) |=> flash_we_n ##1 !byte_lines_oe)
		else $error("write pulse or data hold wrong length");
	a_hv_a6_low: assert property (@(posedge sys_clk) disable iff (!arst_n)
		id_detect_pin && !flash_oe_n |-> !flash_addr[ID_A6_BIT])
		else $error("high-voltage read with address bit 6 high");
	a_hv_sector_addr: assert property (@(posedge sys_clk) disable iff (!arst_n)
		id_detect_pin |-> flash_addr[SECT_MSB:SECT_LSB] == cmd_q.addr[SECT_MSB:SECT_LSB]
			&& flash_addr[ID_SEL_MSB:0] == cmd_q.addr[ID_SEL_MSB:0])
		else $error("high-voltage read address differs from request");
	a_array_read_clean: assert property (@(posedge sys_clk) disable iff (!arst_n)
		$fell(flash_oe_n) && cmd_q.op == FCAF_OP_READ |-> !id_mode && !time_limit_seen)
		else $error("array read issued without reset after id mode or time-out");
	a_id_mode_entry: assert property (@(posedge sys_clk) disable iff (!arst_n)
		$rose(id_mode) |-> $past(cmd_q.op) == FCAF_OP_AUTOSEL && $past(idx_q) == 2'h2)
		else $error("id mode entered without three-write sequence");

	c_autosel: cover property (@(posedge sys_clk) disable iff (!arst_n) $rose(id_mode));
	c_hv_read: cover property (@(posedge sys_clk) disable iff (!arst_n)
		rsp_valid && cmd_q.op == FCAF_OP_HV_READ);
	c_read_after_reset: cover property (@(posedge sys_clk) disable iff (!arst_n)
		rsp_valid && cmd_q.op == FCAF_OP_READ && nwr_q == 2'h1);
	c_time_limit: cover property (@(posedge sys_clk) disable iff (!arst_n) $rose(time_limit_seen));
endmodule

`default_nettype wire

// [rtl/fcaf_pkg.sv]
// Constants and types for the flash command and autoselect host controller
package fcaf_pkg;
	localparam int ADDR_W = 17;
	localparam int DATA_W = 8;
	localparam int SECT_MSB = 16;
	localparam int SECT_LSB = 14;
	localparam int ID_SEL_MSB = 1;
	localparam int ID_A6_BIT = 6;
	localparam int TLF_BIT = 5;
	// Timing, in ns, and derived cycle counts at the system clock
	localparam int CLK_NS = 50;
	localparam int T_ACC_NS = 70;
	localparam int T_WP_NS = 35;
	localparam int T_HV_SETUP_NS = 100;
	localparam int SYNC_CYC = 3;
	localparam int ACC_CYC = (T_ACC_NS + CLK_NS - 1) / CLK_NS;
	localparam int WP_CYC = (T_WP_NS + CLK_NS - 1) / CLK_NS;
	localparam int HV_CYC = (T_HV_SETUP_NS + CLK_NS - 1) / CLK_NS;
	localparam logic [3:0] RD_WAIT = 4'(ACC_CYC + SYNC_CYC);
	localparam logic [3:0] WP_WAIT = 4'(WP_CYC);
	localparam logic [3:0] HV_WAIT = 4'(HV_CYC);
	// Command words
	localparam logic [ADDR_W-1:0] UNLOCK1_ADDR = 17'h00555;
	localparam logic [ADDR_W-1:0] UNLOCK2_ADDR = 17'h002aa;
	localparam logic [ADDR_W-1:0] RESET_ADDR = 17'h00000;
	localparam logic [DATA_W-1:0] UNLOCK1_DATA = 8'haa;
	localparam logic [DATA_W-1:0] UNLOCK2_DATA = 8'h55;
	localparam logic [DATA_W-1:0] AUTOSEL_DATA = 8'h90;
	localparam logic [DATA_W-1:0] RESET_DATA = 8'hf0;
	localparam logic [1:0] AUTOSEL_WRITES = 2'h3;
	// Identification selectors on the low address bits
	localparam logic [1:0] ID_MANUF = 2'h0;
	localparam logic [1:0] ID_DEVICE = 2'h1;
	localparam logic [1:0] ID_PROT = 2'h2;

	typedef enum logic [2:0] {
		FCAF_OP_READ,
		FCAF_OP_WRITE,
		FCAF_OP_RESET,
		FCAF_OP_AUTOSEL,
		FCAF_OP_ID_READ,
		FCAF_OP_HV_READ
	} fcaf_op_t;

	typedef struct packed {
		fcaf_op_t op;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] data;
	} fcaf_cmd_t;

	typedef struct packed {
		logic [DATA_W-1:0] data;
		logic time_limit_flag;
	} fcaf_rsp_t;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] data;
	} fcaf_word_t;
endpackage

// [test/fcaf_flash_model.sv]
// Behavioural model of the byte-wide flash device facing the host controller
`timescale 1ns/1ps
`default_nettype none
module fcaf_flash_model
	import fcaf_pkg::*;
#(
	parameter logic [7:0] MANUF_CODE = 8'h5a, // Arbitrary value
	parameter logic [7:0] DEV_CODE = 8'hc3, // Arbitrary value
	parameter logic [7:0] PGM_CODE = 8'ha0
)(
	// Flash pins
	input wire logic [fcaf_pkg::ADDR_W-1:0] addr,
	input wire logic ce_n,
	input wire logic oe_n,
	input wire logic we_n,
	input wire logic id_pin,
	input wire logic [fcaf_pkg::DATA_W-1:0] dq_i,
	output logic [fcaf_pkg::DATA_W-1:0] dq_o,
	// Test controls
	input wire logic lockout,
	input wire logic tlf_req,
	input wire logic [7:0] prot
);
	logic [2:0] st = 3'h0;
	logic tlf_clr = 1'b0;
	logic pgm_v = 1'b0;
	logic [ADDR_W-1:0] pgm_a = '0;
	logic [7:0] pgm_d = 8'h00;
	logic [ADDR_W-1:0] a_q;
	logic [7:0] rd;
	logic [7:0] last = 8'h00;
	// Case equality keeps unknown pins before reset from looking like a write edge
	wire wr = ce_n === 1'b0 && we_n === 1'b0 && oe_n === 1'b1 && !lockout;
	wire drv = ce_n === 1'b0 && oe_n === 1'b0 && we_n === 1'b1;
	// Flag follows the request until a reset write arrives while it is raised
	wire tlf_q = tlf_req && !tlf_clr;
	////////////////////////////////////////////////////////////////
	always @(posedge wr) a_q = addr;
	always @(negedge wr or posedge lockout) begin
		if (lockout) begin
			st = 3'h0;
		end else if (dq_i == RESET_DATA) begin
			st = 3'h0;
			tlf_clr = tlf_req;
		end else if (st == 3'h4) begin
			// A protected sector keeps its contents
			if (!prot[a_q[SECT_MSB:SECT_LSB]]) begin
				pgm_v = 1'b1;
				pgm_a = a_q;
				pgm_d = a_q[7:0] & 8'hdf & dq_i;
			end
			st = 3'h0;
		end else if (st != 3'h3) begin
			case (st)
			3'h0: st = (a_q == UNLOCK1_ADDR && dq_i == UNLOCK1_DATA) ? 3'h1 : 3'h0;
			3'h1: st = (a_q == UNLOCK2_ADDR && dq_i == UNLOCK2_DATA) ? 3'h2 : 3'h0;
			default: begin
				if (a_q == UNLOCK1_ADDR && dq_i == AUTOSEL_DATA)
					st = 3'h3;
				else if (a_q == UNLOCK1_ADDR && dq_i == PGM_CODE)
					st = 3'h4;
				else
					st = 3'h0;
			end
			endcase
		end
	end
	always @* begin
		if ((id_pin && !addr[ID_A6_BIT]) || st == 2'h3) begin
			case (addr[1:0])
			ID_MANUF: rd = MANUF_CODE;
			ID_DEVICE: rd = DEV_CODE;
			ID_PROT: rd = {7'h00, prot[addr[SECT_MSB:SECT_LSB]]};
			default: rd = 8'h00;
			endcase
		end else
			rd = ((pgm_v && addr == pgm_a) ? pgm_d : (addr[7:0] & 8'hdf)) | {2'h0, tlf_q, 5'h00};
		if (drv)
			last = rd;
	end
	// Released lines show the inverse so a stale value never passes
	assign dq_o = drv ? rd : ~last;
endmodule
`default_nettype wire

// [test/fcaf_host_tb.sv]
// Self-checking testbench for the flash host controller
`timescale 1ns/1ps
`default_nettype none
module fcaf_host_tb;
	import fcaf_pkg::*;
	localparam logic [7:0] MANUF = 8'h5a;
	localparam logic [7:0] DEV = 8'hc3;
	localparam logic [7:0] PGM = 8'ha0;
	logic sys_clk = 1'b0;
	logic arst_n = 1'b0;
	logic cmd_valid = 1'b0;
	fcaf_cmd_t cmd = '0;
	logic cmd_ready, rsp_valid, id_mode, time_limit_seen;
	logic flash_ce_n, flash_oe_n, flash_we_n, id_detect_pin, byte_lines_oe;
	fcaf_rsp_t rsp;
	logic [ADDR_W-1:0] flash_addr;
	logic [DATA_W-1:0] byte_lines_o, dev_dq;
	wire logic [DATA_W-1:0] byte_lines_i = byte_lines_oe ? byte_lines_o : dev_dq;
	logic lockout = 1'b0;
	logic tlf_req = 1'b0;
	logic [7:0] prot = 8'h00;
	int fails = 0;
	int check_count = 0;
	always #25 sys_clk = ~sys_clk;
	fcaf_host u_dut (.sys_clk(sys_clk), .arst_n(arst_n), .cmd_valid(cmd_valid), .cmd(cmd),
		.cmd_ready(cmd_ready), .rsp_valid(rsp_valid), .rsp(rsp), .id_mode(id_mode),
		.time_limit_seen(time_limit_seen), .flash_addr(flash_addr), .flash_ce_n(flash_ce_n),
		.flash_oe_n(flash_oe_n), .flash_we_n(flash_we_n), .id_detect_pin(id_detect_pin),
		.byte_lines_i(byte_lines_i), .byte_lines_o(byte_lines_o), .byte_lines_oe(byte_lines_oe));
	fcaf_flash_model #(.MANUF_CODE(MANUF), .DEV_CODE(DEV), .PGM_CODE(PGM)) u_dev (.addr(flash_addr),
		.ce_n(flash_ce_n), .oe_n(flash_oe_n), .we_n(flash_we_n), .id_pin(id_detect_pin),
		.dq_i(byte_lines_o), .dq_o(dev_dq), .lockout(lockout), .tlf_req(tlf_req), .prot(prot));
	////////////////////////////////////////////////////////////////
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		check_count++;
		if (seen !== exp) begin
			fails++;
			$display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic test_done;
		if (fails == 0 && check_count > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	// Ready seen at a falling edge means the next rising edge takes it
	task automatic op(input fcaf_op_t o, input logic [ADDR_W-1:0] a, input logic [7:0] d);
		int n;
		n = 0;
		@(negedge sys_clk);
		cmd_valid = 1'b1;
		cmd = '{op: o, addr: a, data: d};
		while (cmd_ready !== 1'b1 && n < 50) begin
			@(negedge sys_clk);
			n++;
		end
		@(negedge sys_clk);
		cmd_valid = 1'b0;
		while (rsp_valid !== 1'b1 && n < 100) begin
			@(negedge sys_clk);
			n++;
		end
		if (n >= 100)
			fails++;
	endtask
	function automatic logic [7:0] arr(input logic [ADDR_W-1:0] a);
		return a[7:0] & 8'hdf;
	endfunction
	initial begin
		#(50 * 5000);
		fails++;
		test_done();
	end
	initial begin
		repeat (12) @(negedge sys_clk);
		arst_n = 1'b1;
		op(FCAF_OP_READ, 17'h1c0a5, 8'h00);
		check(rsp.data, arr(17'h1c0a5));
		op(FCAF_OP_HV_READ, 17'h00040, 8'h00);
		check(rsp.data, MANUF);
		op(FCAF_OP_HV_READ, 17'h00001, 8'h00);
		check(rsp.data, DEV);
		for (int j = 0; j < 2; j++) begin
			for (int i = 0; i < 8; i++) begin
				op(j ? FCAF_OP_ID_READ : FCAF_OP_HV_READ, {3'(i), 14'h0002}, 8'h00);
				check(rsp.data, {7'h00, prot[i]});
			end
			prot = 8'ha5;
			op(FCAF_OP_AUTOSEL, 17'h00000, 8'h00);
		end
		check({7'h00, id_mode}, 8'h01);
		op(FCAF_OP_ID_READ, 17'h00100, 8'h00);
		check(rsp.data, MANUF);
		op(FCAF_OP_ID_READ, 17'h1c101, 8'h00);
		check(rsp.data, DEV);
		op(FCAF_OP_RESET, 17'h00000, 8'h00);
		check({7'h00, id_mode}, 8'h00);
		op(FCAF_OP_ID_READ, 17'h00100, 8'h00);
		check(rsp.data, arr(17'h00100));
		for (int k = 0; k < 2; k++) begin
			op(FCAF_OP_WRITE, UNLOCK1_ADDR, UNLOCK1_DATA);
			op(FCAF_OP_WRITE, UNLOCK2_ADDR, UNLOCK2_DATA);
			op(FCAF_OP_WRITE, k ? UNLOCK2_ADDR : UNLOCK1_ADDR, k ? AUTOSEL_DATA : 8'h77);
			op(FCAF_OP_ID_READ, 17'h00101, 8'h00);
			check(rsp.data, arr(17'h00101));
		end
		// Sector 0 is protected and sector 1 is not, so only the second program lands
		for (int s = 0; s < 2; s++) begin
			op(FCAF_OP_WRITE, UNLOCK1_ADDR, UNLOCK1_DATA);
			op(FCAF_OP_WRITE, UNLOCK2_ADDR, UNLOCK2_DATA);
			op(FCAF_OP_WRITE, UNLOCK1_ADDR, PGM);
			op(FCAF_OP_WRITE, {3'(s), 14'h0010}, 8'h00);
			op(FCAF_OP_READ, {3'(s), 14'h0010}, 8'h00);
			check(rsp.data, s ? 8'h00 : arr(17'h00010));
		end
		lockout = 1'b1;
		op(FCAF_OP_AUTOSEL, 17'h00000, 8'h00);
		lockout = 1'b0;
		op(FCAF_OP_ID_READ, 17'h00102, 8'h00);
		check(rsp.data, arr(17'h00102));
		op(FCAF_OP_RESET, 17'h00000, 8'h00);
		tlf_req = 1'b1;
		op(FCAF_OP_READ, 17'h00033, 8'h00);
		check(rsp.data, arr(17'h00033) | 8'h20);
		check({7'h00, rsp.time_limit_flag}, 8'h01);
		check({7'h00, time_limit_seen}, 8'h01);
		op(FCAF_OP_READ, 17'h00033, 8'h00);
		check(rsp.data, arr(17'h00033));
		test_done();
	end
endmodule
`default_nettype wire
